// ==== efuse_fault_pkg.sv ====
// Function
// - Standalone or primary role latches every fault except a drain-source switch fault, then retries or stays off per variant.
// - Every restart after a fault except a secondary short circuit goes through the slew-controlled start-up.
// - Secondary role pulses the shared enable low on a fault, primary handles it.
// - Secondary role, primary not acting: hold the chain off and latch off.
// - Secondary latch-off ends only on bias undervoltage or enable below shutdown.
// - Latched fault and indicator clear on power cycle or enable below shutdown.
// - Retry variant: the same clear also resets the retry delay timer.
// - Enable just under undervoltage lockout but above shutdown leaves a latched fault alone.
// - Secondary short circuit: fast trip, current-limited start-up, no latch, indicator high.
// - Limit-set pin open in steady state keeps current sharing engaged, no fault.
// - Limit-set pin shorted in steady state disables current sharing, no fault.
// - Blanking-timer pin high with overcurrent: shutdown after pin-failure timer, latched.
// - Shared enable pulled low externally without under/overvoltage: shutdown, latched.
// - Monitor pin shorted, current over backup threshold for 45 us: shutdown, latched.
// - Monitor pin open in steady state: shutdown, latched, indicator low.
// - Gate-source switch fault persisting 10 us: shutdown, latched, indicator low.
// - Gate-drain switch fault: shutdown, latched, indicator low.
// - Drain-source switch fault: shutdown after start-up timeout, indicator low, not latched.
// - Reference pin open in start-up, current over backup threshold: shutdown, latched.
// - Reference pin shorted in start-up or steady state: shutdown, latched.
// - Limit-set pin open in start-up: shutdown, latched, indicator low.
// - Limit-set pin shorted in start-up, current over backup threshold: shutdown, latched.
// - Over-temperature: latch-off stays off; retry waits to cool, then retry delay.
package efuse_fault_pkg;
	localparam int CLK_MHZ = 125;
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		ns_to_cyc = (c < 1) ? 1 : c;
	endfunction : ns_to_cyc
	localparam int GS_DELAY_NS = 10000;
	localparam int CURRENT_MONITOR_PIN_SHORT_NS = 45000;
	localparam int FAST_TRIP_NS = 160;
	localparam int PIN_FAIL_NS = 8000;
	localparam int STARTUP_TO_NS = 32000;
	localparam int RETRY_NS = 128000;
	localparam int NOTIFY_NS = 400;
	localparam int FAILSAFE_NS = 4000;
	localparam int GS_CYC = ns_to_cyc(GS_DELAY_NS);
	localparam int CURRENT_MONITOR_PIN_SHORT_CYC = ns_to_cyc(CURRENT_MONITOR_PIN_SHORT_NS);
	localparam int FT_CYC = ns_to_cyc(FAST_TRIP_NS);
	localparam int PF_CYC = ns_to_cyc(PIN_FAIL_NS);
	localparam int SU_CYC = ns_to_cyc(STARTUP_TO_NS);
	localparam int RETRY_CYC = ns_to_cyc(RETRY_NS);
	localparam int NOTIFY_CYC = ns_to_cyc(NOTIFY_NS);
	localparam int FAILSAFE_CYC = ns_to_cyc(FAILSAFE_NS);
	localparam logic [7:0] ADR_CFG = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_CAUSE = 8'h08;
	localparam logic [16:0] CFG_RESET = 17'h004E2;
	localparam int CFG_RETRY_BIT = 16;
	localparam int STATUS_LATCH_BIT = 8;
	localparam int STATUS_SEC_BIT = 9;
	localparam int C_OT = 0;
	localparam int C_OCB = 1;
	localparam int C_FT = 2;
	localparam int C_PIN = 3;
	localparam int C_SUTO = 4;
	localparam int C_FET = 5;
	localparam int C_EXT = 6;
	localparam int C_UV = 7;
	localparam int T_OCB = 0;
	localparam int T_FT = 1;
	localparam int T_GS = 2;
	localparam int T_CURRENT_MONITOR_PIN = 3;
	localparam int T_PF = 4;
	localparam int NTMR = 5;
	typedef enum logic [6:0] {
		ST_OFF = 7'h01,
		ST_STARTUP = 7'h02,
		ST_ON = 7'h04,
		ST_LATCHED = 7'h08,
		ST_RETRY = 7'h10,
		ST_NOTIFY = 7'h20,
		ST_FAILSAFE = 7'h40
	} fsm_e;
endpackage : efuse_fault_pkg

// ==== efuse_fault_manager.sv ====
`timescale 1ns/1ps
module efuse_fault_manager import efuse_fault_pkg::*; #(
	parameter int P_CURRENT_MONITOR_PIN_SHORT_CYC = CURRENT_MONITOR_PIN_SHORT_CYC,
	parameter int P_RETRY_CYC = RETRY_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_role_secondary,
	input wire logic i_en_below_uvlo,
	input wire logic i_en_below_sd,
	input wire logic i_vdd_uv,
	input wire logic i_vin_uv,
	input wire logic i_vin_ov,
	input wire logic i_over_temp,
	input wire logic i_oc_over_ocp,
	input wire logic i_oc_over_bkp,
	input wire logic i_short_circuit,
	input wire logic i_current_limit_set_pin_open,
	input wire logic i_current_limit_set_pin_short,
	input wire logic i_current_monitor_pin_open,
	input wire logic i_current_monitor_pin_short,
	input wire logic i_threshold_reference_pin_open,
	input wire logic i_threshold_reference_pin_short,
	input wire logic i_overcurrent_blanking_timer_pin_high,
	input wire logic i_fet_gs,
	input wire logic i_fet_gd,
	input wire logic i_fet_ds,
	input wire logic i_gate_overdrive,
	input wire logic i_shared_switch_enable,
	output logic o_shared_switch_enable_o,
	output logic o_shared_switch_enable_oe,
	output logic o_fault_indicator_o,
	output logic o_fault_indicator_oe,
	output logic o_gate_on,
	output logic o_slew_ramp,
	output logic o_current_limit,
	output logic o_acs_force_on,
	output logic o_acs_disable
);

	////////////////////////////////////////////////////////////////
	function automatic logic tmr_done(input logic [15:0] cnt, input logic [15:0] lim);
		tmr_done = ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
	endfunction : tmr_done

	fsm_e state_ff;
	fsm_e nxt_state;
	logic [16:0] cfg_ff;
	logic [7:0] cause_ff;
	logic [7:0] nxt_cause;
	logic [15:0] tmr_ff [NTMR];
	logic [15:0] tmr_lim [NTMR];
	logic [NTMR-1:0] tcond;
	logic [NTMR-1:0] tdone;
	logic [15:0] seq_cnt_ff;
	logic cl_mode_ff;
	logic ds_flt_ff;
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic shared_switch_enable_oe_ff;
	logic flt_oe_ff;
	logic gate_ff;
	logic slew_ff;
	logic ilimit_ff;
	logic acs_on_ff;
	logic acs_off_ff;
	logic run;
	logic uv_any;
	logic clear_req;
	logic ext_low;
	logic instant;
	logic su_to;
	logic ds_fault;
	logic sec_trip;
	logic latch_fault;
	logic retry_var;
	logic nxt_flt;
	logic nxt_shared_switch_enable;

	////////////////////////////////////////////////////////////////
	assign run = (state_ff == ST_STARTUP) || (state_ff == ST_ON);
	assign uv_any = i_en_below_uvlo | i_en_below_sd | i_vdd_uv | i_vin_uv | i_vin_ov;
	assign clear_req = i_vdd_uv | i_en_below_sd;
	assign retry_var = cfg_ff[CFG_RETRY_BIT];
	// Own drive is excluded so the pulse we send is not read back as a fault
	assign ext_low = !i_shared_switch_enable && !shared_switch_enable_oe_ff && !uv_any && !i_role_secondary;
	assign su_to = (state_ff == ST_STARTUP) && tmr_done(seq_cnt_ff, 16'(SU_CYC));
	assign ds_fault = su_to && i_fet_ds && !i_gate_overdrive;

	always_comb begin
		tcond[T_OCB] = (state_ff == ST_ON) && (i_oc_over_ocp || (i_threshold_reference_pin_open && i_oc_over_bkp));
		tcond[T_FT] = run && i_short_circuit;
		tcond[T_GS] = run && i_fet_gs;
		tcond[T_CURRENT_MONITOR_PIN] = (state_ff == ST_ON) && i_current_monitor_pin_short && i_oc_over_bkp;
		tcond[T_PF] = run && i_overcurrent_blanking_timer_pin_high && (i_oc_over_ocp || i_oc_over_bkp);
		tmr_lim[T_OCB] = cfg_ff[15:0];
		tmr_lim[T_FT] = 16'(FT_CYC);
		tmr_lim[T_GS] = 16'(GS_CYC);
		tmr_lim[T_CURRENT_MONITOR_PIN] = 16'(P_CURRENT_MONITOR_PIN_SHORT_CYC);
		tmr_lim[T_PF] = 16'(PF_CYC);
		for (int i = 0; i < NTMR; i++) begin
			tdone[i] = tcond[i] && tmr_done(tmr_ff[i], tmr_lim[i]);
		end
	end

	// Counts reset on a single quiet cycle: short dips restart the delay
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < NTMR; i++) begin
				tmr_ff[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < NTMR; i++) begin
				if (!tcond[i]) begin
					tmr_ff[i] <= 16'h0000;
				end else if (tmr_ff[i] != 16'hFFFF) begin
					tmr_ff[i] <= tmr_ff[i] + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		instant = run && (i_over_temp || i_fet_gd || i_threshold_reference_pin_short);
		instant = instant || ((state_ff == ST_STARTUP) && i_current_limit_set_pin_open);
		instant = instant || ((state_ff == ST_STARTUP) && i_oc_over_bkp && (i_current_limit_set_pin_short || i_threshold_reference_pin_open));
		instant = instant || ((state_ff == ST_ON) && i_current_monitor_pin_open) || (run && ext_low);
		sec_trip = tdone[T_FT] && i_role_secondary;
		latch_fault = instant || tdone[T_OCB] || tdone[T_GS] || tdone[T_CURRENT_MONITOR_PIN] || tdone[T_PF];
		latch_fault = latch_fault || (tdone[T_FT] && !i_role_secondary) || (su_to && !ds_fault);
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_OFF: begin
				if (!uv_any && !ds_flt_ff && i_shared_switch_enable) begin
					nxt_state = ST_STARTUP;
				end
			end
			ST_STARTUP, ST_ON: begin
				if (uv_any) begin
					nxt_state = ST_OFF;
				end else if (latch_fault) begin
					nxt_state = i_role_secondary ? ST_NOTIFY : ST_LATCHED;
				end else if (ds_fault || sec_trip) begin
					nxt_state = ST_OFF;
				end else if (i_role_secondary && !i_shared_switch_enable && !shared_switch_enable_oe_ff) begin
					nxt_state = ST_OFF;
				end else if ((state_ff == ST_STARTUP) && i_gate_overdrive) begin
					nxt_state = ST_ON;
				end
			end
			ST_LATCHED: begin
				if (clear_req) begin
					nxt_state = ST_OFF;
				end else if (retry_var && !i_over_temp) begin
					nxt_state = ST_RETRY;
				end
			end
			ST_RETRY: begin
				if (clear_req || tmr_done(seq_cnt_ff, 16'(P_RETRY_CYC))) begin
					nxt_state = ST_OFF;
				end
			end
			ST_NOTIFY: begin
				if (clear_req) begin
					nxt_state = ST_OFF;
				end else if ((seq_cnt_ff > 16'(NOTIFY_CYC)) && !i_shared_switch_enable) begin
					nxt_state = ST_OFF;
				end else if (tmr_done(seq_cnt_ff, 16'(NOTIFY_CYC + FAILSAFE_CYC))) begin
					nxt_state = ST_FAILSAFE;
				end
			end
			ST_FAILSAFE: begin
				if (clear_req) begin
					nxt_state = ST_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_ff <= ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// One sequence counter shared by start-up, retry and notify timing
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seq_cnt_ff <= 16'h0000;
		end else if (nxt_state != state_ff) begin
			seq_cnt_ff <= 16'h0000;
		end else if (seq_cnt_ff != 16'hFFFF) begin
			seq_cnt_ff <= seq_cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cl_mode_ff <= 1'b0;
			ds_flt_ff <= 1'b0;
		end else begin
			if (sec_trip && !uv_any && !latch_fault) begin
				cl_mode_ff <= 1'b1;
			end else if (state_ff == ST_ON) begin
				cl_mode_ff <= 1'b0;
			end
			if (run && !uv_any && !latch_fault && ds_fault) begin
				ds_flt_ff <= 1'b1;
			end else if (uv_any) begin
				ds_flt_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_flt = (nxt_state == ST_LATCHED) || (nxt_state == ST_RETRY) || (nxt_state == ST_FAILSAFE);
		nxt_flt = nxt_flt || (nxt_state == ST_NOTIFY);
		nxt_flt = nxt_flt || (ds_flt_ff && !uv_any) || (run && !uv_any && !latch_fault && ds_fault);
		nxt_flt = nxt_flt || ((nxt_state == ST_STARTUP) && i_oc_over_ocp);
		nxt_shared_switch_enable = (nxt_state == ST_FAILSAFE) || (!i_role_secondary && (nxt_state == ST_LATCHED));
		nxt_shared_switch_enable = nxt_shared_switch_enable || (!i_role_secondary && (nxt_state == ST_RETRY));
		nxt_shared_switch_enable = nxt_shared_switch_enable || ((nxt_state == ST_NOTIFY) && ((state_ff != ST_NOTIFY)
			|| (seq_cnt_ff < 16'(NOTIFY_CYC - 1))));
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flt_oe_ff <= 1'b0;
			shared_switch_enable_oe_ff <= 1'b0;
			gate_ff <= 1'b0;
			slew_ff <= 1'b0;
			ilimit_ff <= 1'b0;
			acs_on_ff <= 1'b0;
			acs_off_ff <= 1'b0;
		end else begin
			flt_oe_ff <= nxt_flt;
			shared_switch_enable_oe_ff <= nxt_shared_switch_enable;
			gate_ff <= (nxt_state == ST_STARTUP) || (nxt_state == ST_ON);
			slew_ff <= (nxt_state == ST_STARTUP) && !(cl_mode_ff || sec_trip);
			ilimit_ff <= (nxt_state == ST_STARTUP) && (cl_mode_ff || sec_trip || i_oc_over_ocp);
			acs_on_ff <= (nxt_state == ST_ON) && i_current_limit_set_pin_open;
			acs_off_ff <= (nxt_state == ST_ON) && i_current_limit_set_pin_short && !i_current_limit_set_pin_open;
		end
	end

	assign o_fault_indicator_o = 1'b0;
	assign o_shared_switch_enable_o = 1'b0;
	assign o_fault_indicator_oe = flt_oe_ff;
	assign o_shared_switch_enable_oe = shared_switch_enable_oe_ff;
	assign o_gate_on = gate_ff;
	assign o_slew_ramp = slew_ff;
	assign o_current_limit = ilimit_ff;
	assign o_acs_force_on = acs_on_ff;
	assign o_acs_disable = acs_off_ff;

	////////////////////////////////////////////////////////////////
	// Write lands on the edge where the master samples ack
	logic wr_now;
	assign wr_now = i_wb_cyc && i_wb_stb && i_wb_we && ack_ff;

	always_comb begin
		nxt_cause = cause_ff;
		if (wr_now && (i_wb_adr == ADR_CAUSE) && i_wb_sel[0]) begin
			nxt_cause = cause_ff & ~i_wb_dat[7:0];
		end
		// Set after clear, so a fresh event survives a simultaneous clear
		if (run) begin
			nxt_cause[C_OT] = nxt_cause[C_OT] | i_over_temp;
			nxt_cause[C_OCB] = nxt_cause[C_OCB] | tdone[T_OCB];
			nxt_cause[C_FT] = nxt_cause[C_FT] | tdone[T_FT];
			nxt_cause[C_PIN] = nxt_cause[C_PIN] | (instant & ~i_over_temp & ~i_fet_gd & ~ext_low)
				| tdone[T_CURRENT_MONITOR_PIN] | tdone[T_PF];
			nxt_cause[C_SUTO] = nxt_cause[C_SUTO] | su_to;
			nxt_cause[C_FET] = nxt_cause[C_FET] | i_fet_gd | tdone[T_GS] | ds_fault;
			nxt_cause[C_EXT] = nxt_cause[C_EXT] | ext_low;
			nxt_cause[C_UV] = nxt_cause[C_UV] | uv_any;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cause_ff <= 8'h00;
		end else begin
			cause_ff <= nxt_cause;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_ff <= CFG_RESET;
		end else if (wr_now && (i_wb_adr == ADR_CFG)) begin
			if (i_wb_sel[0]) cfg_ff[7:0] <= i_wb_dat[7:0];
			if (i_wb_sel[1]) cfg_ff[15:8] <= i_wb_dat[15:8];
			if (i_wb_sel[2]) cfg_ff[16] <= i_wb_dat[16];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h00000000;
		end else begin
			ack_ff <= i_wb_cyc && i_wb_stb && !ack_ff;
			if (i_wb_cyc && i_wb_stb && !ack_ff) begin
				unique case (i_wb_adr)
					ADR_CFG: rdat_ff <= {15'h0000, cfg_ff};
					ADR_STATUS: rdat_ff <= {22'h000000, i_role_secondary, flt_oe_ff, 1'b0, state_ff};
					ADR_CAUSE: rdat_ff <= {24'h000000, cause_ff};
					default: rdat_ff <= 32'h00000000;
				endcase
			end
		end
	end

	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;

	////////////////////////////////////////////////////////////////
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	latch_flt_low_a: assert property ((state_ff == ST_LATCHED) |-> o_fault_indicator_oe)
		else $error("Latched state without fault indicator");
	restart_slew_a: assert property ($rose(state_ff == ST_STARTUP) && !cl_mode_ff |-> o_slew_ramp && o_gate_on)
		else $error("Start-up without slew ramp");
	notify_pulse_a: assert property ($rose(state_ff == ST_NOTIFY) |-> o_shared_switch_enable_oe ##1
		(o_shared_switch_enable_oe || state_ff != ST_NOTIFY))
		else $error("Notify pulse too short");
	failsafe_hold_a: assert property ((state_ff == ST_FAILSAFE) |-> o_shared_switch_enable_oe && !o_gate_on)
		else $error("Failsafe not holding chain off");
	failsafe_exit_a: assert property ((state_ff == ST_FAILSAFE) && !clear_req |=> state_ff == ST_FAILSAFE)
		else $error("Failsafe left without clear");
	latch_clear_a: assert property ((state_ff inside {ST_LATCHED, ST_RETRY}) && clear_req |=>
		(state_ff == ST_OFF) && (seq_cnt_ff == 16'h0000))
		else $error("Latched fault not cleared");
	uvlo_keep_a: assert property ((state_ff == ST_LATCHED) && i_en_below_uvlo && !clear_req && !retry_var
		|=> state_ff == ST_LATCHED)
		else $error("Shallow enable dip cleared fault");
	sec_short_a: assert property (sec_trip && !uv_any && !latch_fault |=> (state_ff == ST_OFF) && !o_fault_indicator_oe)
		else $error("Secondary trip mishandled");
	acs_mode_a: assert property ((o_acs_force_on || o_acs_disable) |-> state_ff == ST_ON && !o_fault_indicator_oe)
		else $error("Sharing override outside steady state");
	uv_off_a: assert property (run && uv_any |=> (state_ff == ST_OFF) && !o_gate_on)
		else $error("Undervoltage did not shut down");

	retry_cov: cover property ((state_ff == ST_RETRY) ##1 (state_ff == ST_OFF) ##1 (state_ff == ST_STARTUP));
	failsafe_cov: cover property ($rose(state_ff == ST_FAILSAFE));
	sec_trip_cov: cover property (sec_trip ##[1:4] o_current_limit);

endmodule : efuse_fault_manager

// ==== efuse_chain_model.sv ====
`timescale 1ns/1ps
module efuse_chain_model (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_dut_oe,
	input wire logic i_pull_low,
	input wire logic i_respond,
	input wire logic i_clear,
	output logic o_line
);
	logic hold_ff;
	////////////////////////////////////////////////////////////////////////
	// Primary reaction to a notify pulse, held until the host clears it
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_ff <= 1'b0;
		end else if (i_clear) begin
			hold_ff <= 1'b0;
		end else if (i_respond && i_dut_oe) begin
			hold_ff <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Wired line with pull-up: released means high, never a stale value
	assign o_line = !(i_dut_oe || i_pull_low || hold_ff);
endmodule : efuse_chain_model

// ==== efuse_fault_manager_bench.sv ====
`timescale 1ns/1ps
module efuse_fault_manager_bench;
	import efuse_fault_pkg::*;
	localparam logic [13:0] TM [9] = '{14'h0001, 14'h0004, 14'h0008, 14'h0012, 14'h0020, 14'h0042, 14'h0080,
		14'h0100, 14'h0200};
	localparam int TD [9] = '{8, 20, 0, 16, 0, 1000, 1250, 0, 0};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic ack;
	logic role = 1'b0;
	logic enable_undervoltage_input = 1'b0;
	logic en_sd = 1'b0;
	logic vdd_uv = 1'b0;
	logic [13:0] f = 14'h0000;
	logic pull = 1'b0;
	logic resp = 1'b0;
	logic mclr = 1'b0;
	logic ds = 1'b0;
	logic god = 1'b1;
	logic [31:0] r;
	logic line;
	logic shared_switch_enable_oe;
	logic flt_oe;
	logic gate_on;
	logic ramp;
	logic climit;
	logic acs_on;
	logic acs_off;
	int n_mismatch = 0;
	int checks = 0;
	int i;
	int k;
	logic [31:0] q;
	always #4 clk = ~clk;
	efuse_fault_manager #(.P_CURRENT_MONITOR_PIN_SHORT_CYC(16), .P_RETRY_CYC(32)) i_efuse_fault_manager (
		.i_ref_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_role_secondary(role),
		.i_en_below_uvlo(enable_undervoltage_input), .i_en_below_sd(en_sd), .i_vdd_uv(vdd_uv), .i_vin_uv(f[11]),
		.i_vin_ov(f[10]), .i_over_temp(f[9]), .i_oc_over_ocp(f[0]), .i_oc_over_bkp(f[1]),
		.i_short_circuit(f[2]), .i_current_limit_set_pin_open(f[12]), .i_current_limit_set_pin_short(f[13]), .i_current_monitor_pin_open(f[3]),
		.i_current_monitor_pin_short(f[4]), .i_threshold_reference_pin_open(1'b0), .i_threshold_reference_pin_short(f[5]), .i_overcurrent_blanking_timer_pin_high(f[6]), .i_fet_gs(f[7]),
		.i_fet_gd(f[8]), .i_fet_ds(ds), .i_gate_overdrive(god), .i_shared_switch_enable(line),
		.o_shared_switch_enable_o(), .o_shared_switch_enable_oe(shared_switch_enable_oe), .o_fault_indicator_o(),
		.o_fault_indicator_oe(flt_oe), .o_gate_on(gate_on), .o_slew_ramp(ramp), .o_current_limit(climit),
		.o_acs_force_on(acs_on), .o_acs_disable(acs_off));
	efuse_chain_model i_efuse_chain_model (.i_ref_clk(clk), .i_reset_n(rst_n), .i_dut_oe(shared_switch_enable_oe),
		.i_pull_low(pull), .i_respond(resp), .i_clear(mclr), .o_line(line));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] st_exp(input fsm_e s, input logic oe, input logic sec);
		st_exp = {22'h000000, sec, oe, 1'b0, s};
	endfunction : st_exp
	task close_out;
		$display("Counts: checks=%0d mismatches=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task bail;
		n_mismatch++;
		$display("CHECK FAILED at %0t: wait bound used up", $time);
		close_out;
	endtask : bail
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task chk_reg(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: register got %h expected %h", $time, g, e);
		end
	endtask : chk_reg
	task chk_pin(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: output got %b expected %b", $time, g, e);
		end
	endtask : chk_pin
	// Single classic cycle; one idle cycle always follows the release
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n == 20) bail;
	endtask : wb
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h00000000);
		chk_reg(q, e);
	endtask : rd_chk
	task clear;
		en_sd <= 1'b1;
		tick(3);
		en_sd <= 1'b0;
		for (k = 0; k < 40 && ramp !== 1'b1; k++) tick(1);
		if (k == 40) bail;
		chk_pin(ramp, 1'b1);
		tick(6);
	endtask : clear
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(80486));
		tick(20);
		rst_n <= 1'b1;
		tick(8);
		rd_chk(ADR_CFG, {15'h0000, CFG_RESET});
		rd_chk(8'h0C, 32'h00000000);
		// Kept apart from q, which every bus cycle overwrites
		r = $urandom();
		wb(1'b1, ADR_CFG, r);
		rd_chk(ADR_CFG, {15'h0000, r[16:0]});
		wb(1'b1, ADR_CFG, 32'h00000008);
		rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b0));
		$display("Test reset and registers done");
		// Random short bursts stay below the blanking count
		for (i = 0; i < 12; i++) begin
			f <= 14'h0001;
			tick($urandom_range(1, 6));
			f <= 14'h0000;
			tick(2);
			chk_pin(flt_oe, 1'b0);
		end
		rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b0));
		$display("Test transient overcurrent done");
		for (i = 0; i < 9; i++) begin
			f <= TM[i];
			if (TD[i] > 2) begin
				tick(TD[i] - 2);
				chk_pin(flt_oe, 1'b0);
			end
			tick(4);
			f <= 14'h0000;
			rd_chk(ADR_STATUS, st_exp(ST_LATCHED, 1'b1, 1'b0));
			chk_pin(gate_on, 1'b0);
			if (i == 0) begin
				enable_undervoltage_input <= 1'b1;
				tick(5);
				enable_undervoltage_input <= 1'b0;
				rd_chk(ADR_STATUS, st_exp(ST_LATCHED, 1'b1, 1'b0));
			end
			clear;
			rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b0));
		end
		$display("Test latched faults done");
		for (i = 10; i < 12; i++) begin
			f <= 14'h0001 << i;
			tick(4);
			chk_pin(gate_on, 1'b0);
			chk_pin(flt_oe, 1'b0);
			f <= 14'h0000;
			tick(10);
			rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b0));
		end
		f <= 14'h1000;
		tick(4);
		chk_pin(acs_on, 1'b1);
		f <= 14'h2000;
		tick(4);
		chk_pin(acs_off, 1'b1);
		chk_pin(flt_oe, 1'b0);
		f <= 14'h0000;
		pull <= 1'b1;
		tick(4);
		pull <= 1'b0;
		rd_chk(ADR_STATUS, st_exp(ST_LATCHED, 1'b1, 1'b0));
		clear;
		$display("Test undervoltage, sharing pins, external line done");
		role <= 1'b1;
		resp <= 1'b1;
		f <= 14'h0100;
		tick(2);
		f <= 14'h0000;
		tick(10);
		chk_pin(shared_switch_enable_oe, 1'b1);
		tick(60);
		chk_pin(shared_switch_enable_oe, 1'b0);
		rd_chk(ADR_STATUS, st_exp(ST_OFF, 1'b0, 1'b1));
		mclr <= 1'b1;
		tick(1);
		mclr <= 1'b0;
		resp <= 1'b0;
		tick(10);
		rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b1));
		f <= 14'h0100;
		tick(2);
		f <= 14'h0000;
		tick(570);
		rd_chk(ADR_STATUS, st_exp(ST_FAILSAFE, 1'b1, 1'b1));
		chk_pin(shared_switch_enable_oe, 1'b1);
		enable_undervoltage_input <= 1'b1;
		tick(5);
		enable_undervoltage_input <= 1'b0;
		rd_chk(ADR_STATUS, st_exp(ST_FAILSAFE, 1'b1, 1'b1));
		vdd_uv <= 1'b1;
		tick(3);
		vdd_uv <= 1'b0;
		tick(10);
		rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b1));
		f <= 14'h0004;
		for (k = 0; k < 100 && climit !== 1'b1; k++) tick(1);
		if (k == 100) bail;
		f <= 14'h0000;
		chk_pin(climit, 1'b1);
		chk_pin(flt_oe, 1'b0);
		tick(10);
		rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b1));
		$display("Test secondary role done");
		role <= 1'b0;
		wb(1'b1, ADR_CFG, 32'h00010008);
		f <= 14'h0200;
		tick(40);
		rd_chk(ADR_STATUS, st_exp(ST_LATCHED, 1'b1, 1'b0));
		f <= 14'h0000;
		tick(10);
		chk_pin(gate_on, 1'b0);
		tick(40);
		rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b0));
		$display("Test retry variant done");
		// Gate never reaches overdrive, so start-up runs into its timeout
		god <= 1'b0;
		ds <= 1'b1;
		en_sd <= 1'b1;
		tick(3);
		en_sd <= 1'b0;
		tick(SU_CYC + 10);
		chk_pin(flt_oe, 1'b1);
		chk_pin(gate_on, 1'b0);
		rd_chk(ADR_STATUS, st_exp(ST_OFF, 1'b1, 1'b0));
		ds <= 1'b0;
		god <= 1'b1;
		clear;
		rd_chk(ADR_STATUS, st_exp(ST_ON, 1'b0, 1'b0));
		$display("Test drain-source switch fault done");
		close_out;
	end
endmodule : efuse_fault_manager_bench
